// *** pkg/bbtc_params.svh ***
// constants for the baseband trigger controller
`ifndef BBTC_PARAMS_SVH
`define BBTC_PARAMS_SVH
`define BBTC_STYLE_REPEAT   2'h0
`define BBTC_STYLE_ONESHOT  2'h1
`define BBTC_STYLE_GATED    2'h2
`define BBTC_RESP_FREE      2'h0
`define BBTC_RESP_WAIT      2'h1
`define BBTC_RESP_RESTART   2'h2
`define BBTC_SRC_PANEL      2'h0
`define BBTC_SRC_REMOTE     2'h1
`define BBTC_SRC_REAR       2'h2
`define BBTC_DELAY_MAX      20'hFFFFF
`define BBTC_RST_STYLE      2'h0
`define BBTC_RST_RESP       2'h0
`define BBTC_RST_GATE_LVL   1'h0
`define BBTC_RST_SRC        2'h0
`define BBTC_RST_POL        1'h0
`define BBTC_RST_DLY_EN     1'h0
`define BBTC_RST_DLY        20'h00000
`endif

// *** pkg/bbtc_pkg.sv ***
// types for the baseband trigger controller
package bbtc_pkg;
	typedef struct packed {
		logic [1:0]  style;
		logic [1:0]  resp;
		logic        gate_lvl;
		logic [1:0]  src;
		logic        rear_pol;
		logic        dly_en;
		logic [19:0] dly_bits;
	} bbtc_cfg_t;

	typedef enum logic [4:0] {
		BBTC_IDLE  = 5'b00001,
		BBTC_DELAY = 5'b00010,
		BBTC_RUN   = 5'b00100,
		BBTC_RELD  = 5'b01000,
		BBTC_FLUSH = 5'b10000
	} bbtc_state_t;
endpackage

// *** src/bbtc_top.sv ***
// baseband trigger controller: trigger decode, delay, playback gating, skid buffer
// Functional notes
// RL1 - trigger style: repeating 0, one-shot 1, gated 2; resets to repeating
// RL2 - repeating response: free 0, wait 1, restart 2; resets free; repeating only
// RL3 - repeating free-run streams continuously until enable cleared or style changed
// RL4 - repeating wait: idle until valid trigger, then stream
// RL5 - repeating restart: trigger aborts output, regenerates, reloads, resumes
// RL6 - gated: stream only while rear input sits at selected active level
// RL7 - gate level: low 0, high 1; resets low
// RL8 - one-shot: one pass per accepted trigger; triggers ignored during a pass
// RL9 - trigger source: panel 0, remote 1, rear input 2; resets panel
// RL10 - rear input polarity: 0 active high, 1 active low; resets 0
// RL11 - rear trigger waits programmed bit periods, 0 to 1048575, when delay enabled; a restart trigger while running reloads at once, without the delay
// RL12 - delay applies only while delay switch set; cleared by default
`timescale 1ns/1ps
`include "bbtc_params.svh"
module bbtc_top
	import bbtc_pkg::*;
#(
	parameter int DW = 16 // sample width
) (
	input  wire logic          i_clk_sys,    // 125 MHz clock
	input  wire logic          i_rstn,       // async reset, active low
	input  wire logic          i_cfg_we,     // load configuration pulse
	input  wire bbtc_cfg_t     i_cfg,        // configuration word
	input  wire logic          i_bb_en,      // baseband enable
	input  wire logic          i_panel_trg,  // front panel trigger pulse
	input  wire logic          i_remote_trg, // remote trigger pulse
	input  wire logic          i_rear_trg,   // rear pin, asynchronous
	input  wire logic          i_bit_tick,   // one pulse per bit period
	input  wire logic          i_last,       // current sample ends the pass
	input  wire logic [DW-1:0] i_smp,        // sample from generator
	input  wire logic          i_smp_vld,    // sample valid
	input  wire logic          i_out_rdy,    // receiver ready
	output logic               o_smp_rdy,    // buffer can take a sample
	output logic               o_regen,      // regenerate data pulse
	output logic               o_rewind,     // restart sequence pulse
	output logic [DW-1:0]      o_out,        // sample out
	output logic               o_out_vld,    // sample out valid
	output logic               o_running,    // playback active
	output bbtc_cfg_t          o_cfg         // configuration readback
);
	bbtc_cfg_t   cfg_ff, nxt_cfg;
	bbtc_state_t st_ff, nxt_st;
	logic [2:0]  rsy_ff;
	logic        rear_ff, nxt_rear;
	logic [19:0] dcnt_ff, nxt_dcnt;
	logic        regen_ff, nxt_regen, rew_ff, nxt_rew;
	logic [DW-1:0] b0_ff, b1_ff, nxt_b0, nxt_b1;
	logic [1:0]  cnt_ff, nxt_cnt;
	logic        gate_on, pulse_trg, trg, flow, push, pop, style_chg;

	// configuration register
	always_comb begin
		nxt_cfg = cfg_ff;
		if (i_cfg_we) begin
			nxt_cfg = i_cfg;
		end
	end
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			cfg_ff <= '{`BBTC_RST_STYLE, `BBTC_RST_RESP, `BBTC_RST_GATE_LVL, `BBTC_RST_SRC, // RL1 RL2 RL7 RL9
				`BBTC_RST_POL, `BBTC_RST_DLY_EN, `BBTC_RST_DLY}; // RL10 RL12
		end else begin
			cfg_ff <= nxt_cfg;
		end
	end
	assign style_chg = i_cfg_we && (i_cfg.style != cfg_ff.style);

	// rear pin: three stages, level accepted when last two agree
	always_comb begin
		nxt_rear = rear_ff;
		if (rsy_ff[1] == rsy_ff[2]) begin
			nxt_rear = rsy_ff[2];
		end
	end
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			rsy_ff  <= 3'h0;
			rear_ff <= 1'h0;
		end else begin
			rsy_ff  <= {rsy_ff[1:0], i_rear_trg};
			rear_ff <= nxt_rear;
		end
	end

	logic rear_act, rear_d_ff;
	assign rear_act = rear_ff ^ cfg_ff.rear_pol; // RL10
	assign gate_on  = (rear_ff == cfg_ff.gate_lvl); // RL6 RL7
	// edge taken from the pin level itself: a polarity change alone is no trigger
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			rear_d_ff <= 1'h0;
		end else begin
			rear_d_ff <= rear_ff;
		end
	end

	// source select; rear input triggers on its active edge
	always_comb begin
		case (cfg_ff.src) // RL9
			`BBTC_SRC_PANEL:  pulse_trg = i_panel_trg;
			`BBTC_SRC_REMOTE: pulse_trg = i_remote_trg;
			`BBTC_SRC_REAR:   pulse_trg = rear_act && (rear_ff != rear_d_ff);
			default:          pulse_trg = 1'b0;
		endcase
	end
	logic use_dly;
	assign use_dly = (cfg_ff.src == `BBTC_SRC_REAR) && cfg_ff.dly_en && (cfg_ff.dly_bits != 20'h00000); // RL11 RL12

	// playback state machine
	always_comb begin
		nxt_st    = st_ff;
		nxt_dcnt  = dcnt_ff;
		nxt_regen = 1'b0;
		nxt_rew   = 1'b0;
		trg       = 1'b0;
		case (st_ff)
			BBTC_IDLE: begin
				if (i_bb_en) begin
					if (cfg_ff.style == `BBTC_STYLE_GATED) begin
						nxt_st = BBTC_RUN; // RL6
					end else if (cfg_ff.style == `BBTC_STYLE_REPEAT && cfg_ff.resp == `BBTC_RESP_FREE) begin
						nxt_st = BBTC_RUN; // RL3
					end else if (pulse_trg) begin
						trg = 1'b1;
					end
				end
			end
			BBTC_DELAY: begin
				if (i_bit_tick) begin
					nxt_dcnt = dcnt_ff - 20'h00001; // RL11
					if (dcnt_ff == 20'h00001) begin
						nxt_st = BBTC_RUN;
						nxt_rew = 1'b1;
					end
				end
			end
			BBTC_RUN: begin
				if (cfg_ff.style == `BBTC_STYLE_ONESHOT && i_last && push) begin
					nxt_st = BBTC_IDLE; // RL8
				end else if (cfg_ff.style == `BBTC_STYLE_REPEAT && cfg_ff.resp == `BBTC_RESP_RESTART
					&& pulse_trg) begin
					nxt_st    = BBTC_RELD; // RL5
					nxt_regen = 1'b1;
				end
			end
			BBTC_RELD: begin
				nxt_st  = BBTC_FLUSH; // RL5
				nxt_rew = 1'b1;
			end
			BBTC_FLUSH: begin
				nxt_st = BBTC_RUN;
			end
			default: nxt_st = BBTC_IDLE;
		endcase
		if (trg) begin
			// wait and one-shot styles start here; restart idles also wait for a trigger
			nxt_regen = 1'b0;
			if (use_dly) begin
				nxt_st   = BBTC_DELAY;
				nxt_dcnt = cfg_ff.dly_bits;
			end else begin
				nxt_st  = BBTC_RUN; // RL4 RL8
				nxt_rew = 1'b1;
			end
		end
		if (!i_bb_en || style_chg) begin
			nxt_st = BBTC_IDLE; // RL3
		end
	end
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			st_ff    <= BBTC_IDLE;
			dcnt_ff  <= 20'h00000;
			regen_ff <= 1'h0;
			rew_ff   <= 1'h0;
		end else begin
			st_ff    <= nxt_st;
			dcnt_ff  <= nxt_dcnt;
			regen_ff <= nxt_regen;
			rew_ff   <= nxt_rew;
		end
	end

	// samples flow only while running; gated style also needs the gate level
	assign flow = (st_ff == BBTC_RUN) && (cfg_ff.style != `BBTC_STYLE_GATED || gate_on); // RL6
	// two-entry skid buffer; old data is dropped on reload
	assign push = flow && i_smp_vld && (cnt_ff != 2'h2);
	assign pop  = o_out_vld && i_out_rdy;
	always_comb begin
		nxt_b0  = b0_ff;
		nxt_b1  = b1_ff;
		nxt_cnt = cnt_ff;
		if (pop) begin
			nxt_b0  = b1_ff;
			nxt_cnt = nxt_cnt - 2'h1;
		end
		if (push) begin
			if (nxt_cnt == 2'h0) begin
				nxt_b0 = i_smp;
			end else begin
				nxt_b1 = i_smp;
			end
			nxt_cnt = nxt_cnt + 2'h1;
		end
		// a finished one-shot pass still drains; only reload, disable or style change drop words
		if (st_ff == BBTC_RELD || !i_bb_en || style_chg) begin
			nxt_cnt = 2'h0; // RL5
		end
	end
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			b0_ff  <= '0;
			b1_ff  <= '0;
			cnt_ff <= 2'h0;
		end else begin
			b0_ff  <= nxt_b0;
			b1_ff  <= nxt_b1;
			cnt_ff <= nxt_cnt;
		end
	end

	// registered outputs
	logic rdy_ff, run_ff, vld_ff;
	// ready carries the gate term as well, so a raised ready always means a taken word
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			rdy_ff <= 1'h0;
			run_ff <= 1'h0;
			vld_ff <= 1'h0;
		end else begin
			rdy_ff <= (nxt_cnt != 2'h2) && (nxt_st == BBTC_RUN)
				&& (nxt_cfg.style != `BBTC_STYLE_GATED || nxt_rear == nxt_cfg.gate_lvl); // RL6
			run_ff <= (nxt_st == BBTC_RUN);
			vld_ff <= (nxt_cnt != 2'h0);
		end
	end
	assign o_smp_rdy = rdy_ff;
	assign o_regen   = regen_ff;
	assign o_rewind  = rew_ff;
	assign o_out     = b0_ff;
	assign o_out_vld = vld_ff;
	assign o_running = run_ff;
	assign o_cfg     = cfg_ff;
endmodule

// *** verification/bbtc_props.sv ***
// assertions on the trigger controller ports
`timescale 1ns/1ps
`include "bbtc_params.svh"
module bbtc_props
	import bbtc_pkg::*;
(
	input wire logic      i_clk_sys,   // clk
	input wire logic      i_rstn,      // rst
	input wire logic      i_cfg_we,    // load
	input wire bbtc_cfg_t i_cfg,       // cfg
	input wire logic      i_bb_en,     // en
	input wire logic      i_panel_trg, // trg
	input wire logic      i_smp_vld,   // vld
	input wire logic      i_last,      // end
	input wire logic      i_out_rdy,   // rdy
	input wire logic      o_smp_rdy,   // rdy
	input wire logic      o_regen,     // regen
	input wire logic      o_rewind,    // rewind
	input wire logic      o_out_vld,   // vld
	input wire logic      o_running,   // run
	input wire bbtc_cfg_t o_cfg        // cfg
);
	logic trg;
	logic one;
	logic rst;
	logic wt;
	assign trg = i_panel_trg && !i_cfg_we && o_cfg.src == `BBTC_SRC_PANEL && i_bb_en;
	assign one = o_cfg.style == `BBTC_STYLE_ONESHOT;
	assign rst = o_cfg.style == `BBTC_STYLE_REPEAT && o_cfg.resp == `BBTC_RESP_RESTART;
	assign wt = o_cfg.style == `BBTC_STYLE_REPEAT && o_cfg.resp == `BBTC_RESP_WAIT;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);
	a_cfg_load: assert property (i_cfg_we |=> o_cfg == $past(i_cfg))
		else $error("cfg");
	a_shot_start: assert property (trg && one && !o_running |=> o_running && o_rewind)
		else $error("start");
	a_shot_end: assert property (one && i_smp_vld && o_smp_rdy && i_last && !i_cfg_we |=> !o_running)
		else $error("end");
	a_restart_seq: assert property (trg && rst && o_running |=> o_regen ##1 o_rewind)
		else $error("restart");
	a_wait_idle: assert property (wt && o_cfg.src == `BBTC_SRC_PANEL && !i_panel_trg && !i_cfg_we
		&& !o_running |=> !o_running)
		else $error("wait");
	a_en_stop: assert property (!i_bb_en [*2] |-> !o_running)
		else $error("en");
	a_regen_once: assert property (o_regen |=> !o_regen)
		else $error("regen");
	a_out_hold: assert property (o_out_vld && !i_out_rdy && i_bb_en && !i_cfg_we && !rst |=> o_out_vld)
		else $error("hold");
	a_rdy_run: assert property (o_smp_rdy |-> o_running)
		else $error("rdy");
	a_word_taken: assert property (o_smp_rdy && i_smp_vld && i_bb_en && !i_cfg_we |=> o_out_vld)
		else $error("taken");
	cover property (trg && rst && o_running);
	cover property (o_out_vld && !i_out_rdy);
	cover property ($fell(o_running));
	cover property (o_smp_rdy && i_smp_vld);
endmodule
bind bbtc_top bbtc_props u_props (.*);

// *** verification/bbtc_src.sv ***
// sample source standing in for the generator
`timescale 1ns/1ps
module bbtc_src (
	input wire logic    i_clk_sys, // clk
	input wire logic    i_rstn,    // rst
	input wire logic    o_smp_rdy, // rdy
	input wire logic    o_rewind,  // rewind
	output logic [15:0] i_smp,     // word
	output logic        i_smp_vld, // vld
	output logic        i_last     // end
);
	logic [1:0] cnt;
	logic       tk;
	assign i_smp = {14'h0000, cnt};
	assign i_last = cnt == 2'h3;
	always @(posedge i_clk_sys) begin
		tk <= i_smp_vld && o_smp_rdy;
	end
	// valid follows ready, so a raised word is always taken
	always @(negedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt <= 2'h0;
			i_smp_vld <= 1'h0;
		end else begin
			cnt <= o_rewind ? 2'h0 : cnt + {1'h0, tk};
			i_smp_vld <= o_smp_rdy;
		end
	end
endmodule

// *** verification/bbtc_top_test.sv ***
// self-checking bench for the trigger controller
`timescale 1ns/1ps
`include "bbtc_params.svh"
module bbtc_top_test;
	import bbtc_pkg::*;
	logic        i_clk_sys = 1'h0, i_rstn = 1'h0, i_cfg_we = 1'h0, i_bb_en = 1'h0;
	logic        i_panel_trg = 1'h0, i_remote_trg = 1'h0, i_rear_trg = 1'h0, i_bit_tick = 1'h0;
	logic        i_out_rdy = 1'h1, i_smp_vld, i_last, o_smp_rdy, o_regen, o_rewind, o_out_vld, o_running;
	logic [15:0] i_smp, o_out;
	bbtc_cfg_t   i_cfg = '0, o_cfg, c;
	int          errors = 0, checks_done = 0, cyc = 0, nout = 0, n0, sum = 0, s0;
	// style, response, enable, trigger, running
	logic [6:0]  rows [6] = '{7'h05, 7'h0C, 7'h0F, 7'h00, 7'h24, 7'h17};
	bbtc_top DUT (.*);
	bbtc_src u_src (.*);
	initial forever #4 i_clk_sys = ~i_clk_sys;
	task automatic wrap_up();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge i_clk_sys) begin
		cyc <= cyc + 1;
		nout <= nout + int'(o_out_vld && i_out_rdy);
		sum <= sum + ((o_out_vld && i_out_rdy) ? int'(o_out) : 0);
		if (cyc == 5000) begin
			errors++;
			wrap_up();
		end
	end
	task automatic chk(input logic a, input logic e);
		checks_done++;
		if (a !== e) begin
			errors++;
			$display("[ERR] %0t flag got %b want %b", $time, a, e);
		end
	endtask
	task automatic chk_cfg(input bbtc_cfg_t a, input bbtc_cfg_t e);
		checks_done++;
		if (a !== e) begin
			errors++;
			$display("[ERR] %0t cfg got %h want %h", $time, a, e);
		end
	endtask
	task automatic chk_cnt(input int a, input int e);
		checks_done++;
		if (a != e) begin
			errors++;
			$display("[ERR] %0t count got %0d want %0d", $time, a, e);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge i_clk_sys);
	endtask
	task automatic load(input bbtc_cfg_t v);
		wt(1);
		i_cfg = v;
		i_cfg_we = 1'h1;
		wt(1);
		i_cfg_we = 1'h0;
	endtask
	task automatic fire(input logic tick);
		wt(1);
		i_bit_tick = tick;
		i_panel_trg = !tick;
		wt(1);
		i_bit_tick = 1'h0;
		i_panel_trg = 1'h0;
	endtask
	initial begin
		wt(6);
		i_rstn = 1'h1;
		chk_cfg(o_cfg, '0);
		foreach (rows[k]) begin
			c = '0;
			c.style = rows[k][6:5];
			c.resp = rows[k][4:3];
			i_bb_en = 1'h0;
			load(c);
			chk_cfg(o_cfg, c);
			i_bb_en = rows[k][2];
			if (rows[k][1]) fire(1'h0);
			wt(4);
			chk(o_running, rows[k][0]);
		end
		fire(1'h0);
		chk(o_regen, 1'h1);
		wt(1);
		chk(o_rewind, 1'h1);
		wt(2);
		chk(o_running, 1'h1);
		i_rstn = 1'h0;
		wt(2);
		chk_cfg(o_cfg, '0);
		i_rstn = 1'h1;
		c = '0;
		c.style = `BBTC_STYLE_ONESHOT;
		load(c);
		i_out_rdy = 1'h0;
		n0 = nout;
		s0 = sum;
		fire(1'h0);
		fire(1'h0);
		wt(4);
		chk(o_smp_rdy, 1'h0);
		i_out_rdy = 1'h1;
		wt(12);
		chk(o_running, 1'h0);
		chk_cnt(nout - n0, 4);
		chk_cnt(sum - s0, 6);
		c.style = `BBTC_STYLE_GATED;
		c.gate_lvl = 1'h1;
		load(c);
		wt(8);
		n0 = nout;
		wt(8);
		chk_cnt(nout - n0, 0);
		i_rear_trg = 1'h1;
		wt(10);
		chk(nout > n0, 1'h1);
		c = '0;
		c.resp = `BBTC_RESP_WAIT;
		c.src = `BBTC_SRC_REAR;
		c.rear_pol = 1'h1;
		c.dly_en = 1'h1;
		c.dly_bits = 20'h00003;
		load(c);
		wt(6);
		chk(o_running, 1'h0);
		i_rear_trg = 1'h0;
		wt(8);
		fire(1'h1);
		fire(1'h1);
		chk(o_running, 1'h0);
		fire(1'h1);
		wt(2);
		chk(o_running, 1'h1);
		i_bb_en = 1'h0;
		c.src = `BBTC_SRC_REMOTE;
		load(c);
		i_bb_en = 1'h1;
		fire(1'h0);
		wt(2);
		chk(o_running, 1'h0);
		i_remote_trg = 1'h1;
		wt(1);
		i_remote_trg = 1'h0;
		wt(1);
		chk(o_running, 1'h1);
		i_bb_en = 1'h0;
		c.src = `BBTC_SRC_REAR;
		c.rear_pol = 1'h0;
		c.dly_en = 1'h0;
		load(c);
		i_bb_en = 1'h1;
		i_rear_trg = 1'h1;
		wt(6);
		chk(o_running, 1'h1);
		wrap_up();
	end
endmodule
